// ==== ccrb_clkdiv.v ====
// Clock divider producing a one-cycle tick every (multiplier x divisor) master clocks.
// Assumes a single clock; divisor zero stands for 256.
`timescale 1ns/1ps
module ccrb_clkdiv #(
	parameter MULT = 4 // Master clocks per divisor step.
) (
	input  wire       clock_i, // Master clock.
	input  wire       nrst_i,  // Synchronous reset, active low.
	input  wire [7:0] div_i,   // Divisor, zero meaning 256.
	output reg        tick_o,  // One-cycle pulse at each period end.
	output reg        lvl_o    // Square wave, toggles each half period.
);
	reg  [17:0] cnt_r;
	wire [17:0] period;
	// Zero is taken as 256.
	assign period = (div_i == 8'h00) ? (18'h00100 * MULT[17:0]) : ({10'h000, div_i} * MULT[17:0]);
	always @(posedge clock_i) begin
		if (!nrst_i) begin
			cnt_r  <= 18'h00000;
			tick_o <= 1'b0;
			lvl_o  <= 1'b0;
		end else begin
			if (cnt_r + 18'h00001 >= period) begin
				cnt_r  <= 18'h00000;
				tick_o <= 1'b1;
			end else begin
				cnt_r  <= cnt_r + 18'h00001;
				tick_o <= 1'b0;
			end
			if (cnt_r + 18'h00001 >= period || cnt_r + 18'h00001 == (period >> 1))
				lvl_o <= ~lvl_o;
		end
	end
endmodule // ccrb_clkdiv

// ==== ccrb_defines.vh ====
// Register map, field positions and reset values of the codec control register bank.
// Assumes inclusion by bare name from the design files.
`ifndef CCRB_DEFINES_VH
`define CCRB_DEFINES_VH
`define CCRB_ADDR_NOP     5'h00
`define CCRB_ADDR_MAIN    5'h01
`define CCRB_ADDR_FILT    5'h02
`define CCRB_ADDR_OSDIV   5'h03
`define CCRB_ADDR_SCDIV   5'h04
`define CCRB_ADDR_REF     5'h05
`define CCRB_CMD_RW_BIT   13
`define CCRB_CMD_ADDR_HI  12
`define CCRB_CMD_ADDR_LO  8
`define CCRB_MAIN_RST     7
`define CCRB_MAIN_PDN     6
`define CCRB_MAIN_AUX     5
`define CCRB_MAIN_GAIN_HI 4
`define CCRB_MAIN_GAIN_LO 3
`define CCRB_MAIN_ALB     2
`define CCRB_MAIN_DLB     1
`define CCRB_MAIN_HWREQ   0
`define CCRB_FILT_OVF     5
`define CCRB_FILT_FLAG1   4
`define CCRB_FILT_FLAG0   3
`define CCRB_FILT_PHONE   2
`define CCRB_FILT_DECBYP  1
`define CCRB_FILT_INTBYP  0
`define CCRB_FILT_WMASK   8'h1f
`define CCRB_REF_DACDIS   3
`define CCRB_REF_WMASK    8'h08
`define CCRB_MAIN_RESET   8'h00
`define CCRB_FILT_RESET   8'h00
`define CCRB_OSDIV_RESET  8'h08
`define CCRB_SCDIV_RESET  8'h01
`define CCRB_REF_RESET    8'h00
`define CCRB_OS_MULT      4
`define CCRB_RATE_MULT    64
`define CCRB_SC_MULT      2
`endif

// ==== ccrb_host_model.sv ====
// Host serial port model presenting deserialised secondary command words.
// Assumes one master clock shared with the bank.
`timescale 1ns/1ps
module ccrb_host_model (
	input  wire         clock_i,     // Master clock.
	output logic        cmd_valid_i, // Command strobe.
	output logic [15:0] cmd_word_i   // Command word.
);
	initial begin
		cmd_valid_i = 1'b0;
		cmd_word_i  = 16'h0000;
	end
	// The word is held for the taking edge, then replaced by its inverse.
	task send(input logic [15:0] w);
		@(posedge clock_i);
		cmd_valid_i <= 1'b1;
		cmd_word_i  <= w;
		@(posedge clock_i);
		cmd_valid_i <= 1'b0;
		cmd_word_i  <= ~w;
	endtask
endmodule // ccrb_host_model

// ==== ccrb_properties.sv ====
// Concurrent checks on the ports of the codec control register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module ccrb_properties (
	input wire        clock_i,      // Master clock.
	input wire        nrst_i,       // Reset, active low.
	input wire        cmd_valid_i,  // Command strobe.
	input wire [15:0] cmd_word_i,   // Command word.
	input wire        rd_valid_o,   // Read strobe.
	input wire [7:0]  rd_data_o,    // Read data.
	input wire        soft_reset_o, // Software reset pulse.
	input wire        power_down_o, // Power down.
	input wire        aux_select_o, // Input pair select.
	input wire [1:0]  out_gain_o,   // Gain code.
	input wire        squelch_o     // Squelch.
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!nrst_i);
	wire rd_cmd  = cmd_valid_i && cmd_word_i[13];
	wire wr_main = cmd_valid_i && !cmd_word_i[13] && cmd_word_i[12:8] == 5'h01;
	a_read_answer: assert property (rd_cmd |=> rd_valid_o)
		else $error("read not answered");
	a_no_stray: assert property (!rd_cmd |=> !rd_valid_o)
		else $error("stray read strobe");
	a_nop_zero: assert property (rd_cmd && (cmd_word_i[12:8] == 5'h00 ||
		cmd_word_i[12:8] > 5'h05) |=> rd_data_o == 8'h00) else $error("no-op read not zero");
	a_rst_bit_clear: assert property (rd_cmd && cmd_word_i[12:8] == 5'h01 |=> !rd_data_o[7])
		else $error("reset bit reads one");
	a_reset_cause: assert property (wr_main && cmd_word_i[7] |-> ##[1:2] soft_reset_o)
		else $error("no reset pulse");
	a_reset_once: assert property (soft_reset_o |=> !soft_reset_o)
		else $error("reset pulse too long");
	a_power_follow: assert property (wr_main |-> ##2 power_down_o == $past(cmd_word_i[6], 2))
		else $error("power down wrong");
	a_aux_follow: assert property (wr_main |-> ##2 aux_select_o == $past(cmd_word_i[5], 2))
		else $error("input select wrong");
	a_gain_follow: assert property (wr_main |-> ##2 out_gain_o == $past(cmd_word_i[4:3], 2))
		else $error("gain wrong");
	a_squelch_code: assert property (squelch_o == (out_gain_o == 2'b11))
		else $error("squelch wrong");
	cover property (rd_cmd ##1 rd_valid_o);
	cover property (soft_reset_o);
	cover property (squelch_o);
endmodule // ccrb_properties

bind ccrb_top ccrb_properties u_prop (.*);

// ==== ccrb_top.v ====
// Codec control register bank: decodes secondary command words and drives control outputs.
// Assumes command words arrive already deserialised, one strobe per word, on clock_i.
//
// Operation
// - Command bits 12..8 carry the register address, bits 7..0 the data.
// - Command bit 13 low writes, high reads the addressed register.
// - Address 0 no-op, 1 main, 2 filter, 3 oversample, 4 shift clock, 5 reference.
// - Main bit 7 gives one software reset pulse, then self-clears.
// - Main bit 6 asserts power down of analog section and filters.
// - Main bit 5 selects auxiliary input pair, else primary pair.
// - Main bits 4..3 set output gain: unity, half, quarter, squelch.
// - Main bit 2 asserts analog loopback.
// - Main bit 1 asserts digital loopback.
// - Main bit 0 selects hardware-requested secondary words, else software-requested.
// - Main and filter registers reset to all zeros.
// - Filter register reports decimator overflow flag, meaningful on read only.
// - Filter decimator bypass bit routes data around the decimator.
// - Filter interpolator bypass bit routes data around the interpolator.
// - Oversampling clock is master over four times divisor; rate over 256 times.
// - Oversample divisor zero counts as 256.
// - Oversample divisor resets to eight.
// - Shift clock is master clock over twice the shift divisor.
// - Shift divisor zero counts as 256.
`timescale 1ns/1ps
`include "ccrb_defines.vh"
module ccrb_top (
	input  wire        clock_i,        // Master clock, 125 MHz.
	input  wire        nrst_i,         // Synchronous reset, active low.
	input  wire        cmd_valid_i,    // One-cycle strobe with a command word.
	input  wire [15:0] cmd_word_i,     // Secondary command word.
	input  wire        dec_ovf_i,      // Decimator overflow event pulse.
	output reg         rd_valid_o,     // One-cycle strobe with read data.
	output reg  [7:0]  rd_data_o,      // Read data.
	output reg         soft_reset_o,   // One-cycle software reset pulse.
	output reg         power_down_o,   // Analog and filter power down.
	output reg         aux_select_o,   // Auxiliary input pair selected.
	output reg  [1:0]  out_gain_o,     // Output gain code.
	output reg         squelch_o,      // Output squelched.
	output reg         analog_lb_o,    // Analog loopback.
	output reg         digital_lb_o,   // Digital loopback.
	output reg         hw_sec_req_o,   // Hardware-requested secondary words.
	output reg  [1:0]  flag_o,         // General-purpose flag pins.
	output reg         phone_mode_o,   // Phone mode.
	output reg         dec_bypass_o,   // Decimator bypass.
	output reg         int_bypass_o,   // Interpolator bypass.
	output reg         dac_ref_dis_o,  // DAC reference disabled.
	output reg         oversampling_clock_o, // Oversampling clock level.
	output reg         conv_tick_o,    // One-cycle pulse per conversion.
	output reg         shift_clock_o   // Serial shift clock level.
);
	reg  [7:0] main_control_r;
	reg  [7:0] filter_flag_control_r;
	reg  [7:0] oversample_divisor_r;
	reg  [7:0] shift_clock_divisor_r;
	reg  [7:0] reference_control_r;
	reg        ovf_r;
	reg  [7:0] rd_nxt;
	wire [4:0] addr;
	wire [7:0] wdata;
	wire       is_wr;
	wire       is_rd;
	wire       os_lvl;
	wire       rate_tick;
	wire       sc_lvl;

	// ****************************************
	// Command decode
	// ****************************************
	assign addr  = cmd_word_i[`CCRB_CMD_ADDR_HI:`CCRB_CMD_ADDR_LO];
	assign wdata = cmd_word_i[7:0];
	assign is_wr = cmd_valid_i & ~cmd_word_i[`CCRB_CMD_RW_BIT];
	assign is_rd = cmd_valid_i & cmd_word_i[`CCRB_CMD_RW_BIT];

	always @* begin
		case (addr)
			`CCRB_ADDR_MAIN:  rd_nxt = main_control_r;
			`CCRB_ADDR_FILT:  rd_nxt = {2'b00, ovf_r, filter_flag_control_r[4:0]};
			`CCRB_ADDR_OSDIV: rd_nxt = oversample_divisor_r;
			`CCRB_ADDR_SCDIV: rd_nxt = shift_clock_divisor_r;
			`CCRB_ADDR_REF:   rd_nxt = reference_control_r;
			default:          rd_nxt = 8'h00;
		endcase
	end

	// ****************************************
	// Register file
	// ****************************************
	always @(posedge clock_i) begin
		if (!nrst_i) begin
			main_control_r        <= `CCRB_MAIN_RESET;
			filter_flag_control_r <= `CCRB_FILT_RESET;
			oversample_divisor_r  <= `CCRB_OSDIV_RESET;
			shift_clock_divisor_r <= `CCRB_SCDIV_RESET;
			reference_control_r   <= `CCRB_REF_RESET;
			ovf_r                 <= 1'b0;
			rd_valid_o            <= 1'b0;
			rd_data_o             <= 8'h00;
		end else begin
			rd_valid_o <= is_rd;
			if (is_rd)
				rd_data_o <= rd_nxt;
			// Overflow is sticky until read; a new event in the read cycle wins.
			if (dec_ovf_i)
				ovf_r <= 1'b1;
			else if (is_rd && addr == `CCRB_ADDR_FILT)
				ovf_r <= 1'b0;
			// Reset bit never holds; it only fires the pulse below.
			main_control_r[`CCRB_MAIN_RST] <= 1'b0;
			if (is_wr) begin
				case (addr)
					`CCRB_ADDR_MAIN:
						main_control_r[6:0] <= wdata[6:0];
					`CCRB_ADDR_FILT:
						filter_flag_control_r <= wdata & `CCRB_FILT_WMASK;
					`CCRB_ADDR_OSDIV:
						oversample_divisor_r <= wdata;
					`CCRB_ADDR_SCDIV:
						shift_clock_divisor_r <= wdata;
					`CCRB_ADDR_REF:
						reference_control_r <= wdata & `CCRB_REF_WMASK;
					default: begin
					end
				endcase
			end
		end
	end

	// ****************************************
	// Control outputs
	// ****************************************
	always @(posedge clock_i) begin
		if (!nrst_i) begin
			soft_reset_o  <= 1'b0;
			power_down_o  <= 1'b0;
			aux_select_o  <= 1'b0;
			out_gain_o    <= 2'b00;
			squelch_o     <= 1'b0;
			analog_lb_o   <= 1'b0;
			digital_lb_o  <= 1'b0;
			hw_sec_req_o  <= 1'b0;
			flag_o        <= 2'b00;
			phone_mode_o  <= 1'b0;
			dec_bypass_o  <= 1'b0;
			int_bypass_o  <= 1'b0;
			dac_ref_dis_o <= 1'b0;
			oversampling_clock_o <= 1'b0;
			conv_tick_o   <= 1'b0;
			shift_clock_o <= 1'b0;
		end else begin
			soft_reset_o  <= is_wr && addr == `CCRB_ADDR_MAIN && wdata[`CCRB_MAIN_RST];
			power_down_o  <= main_control_r[`CCRB_MAIN_PDN];
			aux_select_o  <= main_control_r[`CCRB_MAIN_AUX];
			out_gain_o    <= main_control_r[`CCRB_MAIN_GAIN_HI:`CCRB_MAIN_GAIN_LO];
			squelch_o     <= &main_control_r[`CCRB_MAIN_GAIN_HI:`CCRB_MAIN_GAIN_LO];
			analog_lb_o   <= main_control_r[`CCRB_MAIN_ALB];
			digital_lb_o  <= main_control_r[`CCRB_MAIN_DLB];
			hw_sec_req_o  <= main_control_r[`CCRB_MAIN_HWREQ];
			flag_o        <= filter_flag_control_r[`CCRB_FILT_FLAG1:`CCRB_FILT_FLAG0];
			phone_mode_o  <= filter_flag_control_r[`CCRB_FILT_PHONE];
			dec_bypass_o  <= filter_flag_control_r[`CCRB_FILT_DECBYP];
			int_bypass_o  <= filter_flag_control_r[`CCRB_FILT_INTBYP];
			dac_ref_dis_o <= reference_control_r[`CCRB_REF_DACDIS];
			oversampling_clock_o <= os_lvl;
			conv_tick_o   <= rate_tick;
			shift_clock_o <= sc_lvl;
		end
	end

	// ****************************************
	// Clock dividers
	// ****************************************
	// Oversampling clock period is 4 x divisor; zero divisor handled as 256.
	ccrb_clkdiv #(.MULT(`CCRB_OS_MULT)) u_osdiv (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.div_i   (oversample_divisor_r),
		.tick_o  (),
		.lvl_o   (os_lvl)
	);
	// Conversion tick every 256 x divisor master clocks.
	ccrb_clkdiv #(.MULT(`CCRB_RATE_MULT * `CCRB_OS_MULT)) u_ratediv (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.div_i   (oversample_divisor_r),
		.tick_o  (rate_tick),
		.lvl_o   ()
	);
	// Shift clock toggles every divisor clocks: full period 2 x divisor.
	ccrb_clkdiv #(.MULT(`CCRB_SC_MULT)) u_scdiv (
		.clock_i (clock_i),
		.nrst_i  (nrst_i),
		.div_i   (shift_clock_divisor_r),
		.tick_o  (),
		.lvl_o   (sc_lvl)
	);
endmodule // ccrb_top

// ==== tb.sv ====
// Self-checking testbench of the codec control register bank.
// Assumes the design, the host model and the checker are compiled first.
`timescale 1ns/1ps
module tb;
	logic clock_i = 0, nrst_i = 0, dec_ovf_i = 0, sr_seen = 0;
	wire cmd_valid_i, rd_valid_o, soft_reset_o, power_down_o, aux_select_o, squelch_o;
	wire analog_lb_o, digital_lb_o, hw_sec_req_o, phone_mode_o, dec_bypass_o, int_bypass_o;
	wire dac_ref_dis_o, oversampling_clock_o, conv_tick_o, shift_clock_o;
	wire [15:0] cmd_word_i;
	wire [7:0] rd_data_o;
	wire [1:0] out_gain_o, flag_o;
	int failures = 0, cmp_count = 0;
	time t0, t1;
	always #4 clock_i = ~clock_i;
	always @(posedge clock_i) if (soft_reset_o === 1'b1) sr_seen <= 1'b1;
	ccrb_host_model host (.clock_i(clock_i), .cmd_valid_i(cmd_valid_i), .cmd_word_i(cmd_word_i));
	ccrb_top uut (.*);
	task report_and_stop;
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		host.send({3'b000, a, d});
		repeat (2) @(posedge clock_i);
		#1;
	endtask
	task rd(input logic [4:0] a, input logic [7:0] e, input string nm);
		int i;
		host.send({3'b001, a, 8'h00});
		#1;
		for (i = 0; i < 4 && rd_valid_o !== 1'b1; i++) @(posedge clock_i) #1;
		if (i == 4) begin
			failures++;
			report_and_stop;
		end
		chk(rd_data_o, e, nm);
	endtask
	function logic sig(input int s);
		return s == 0 ? oversampling_clock_o : s == 1 ? conv_tick_o : shift_clock_o;
	endfunction
	task per(input int s, input int e, input string nm);
		int n, k;
		logic p;
		p = 1'b1;
		k = 0;
		n = 0;
		while (k < 4) begin
			@(posedge clock_i) #1;
			if (++n > 8000) begin
				failures++;
				report_and_stop;
			end
			if (sig(s) === 1'b1 && p === 1'b0) begin
				k++;
				t0 = t1;
				t1 = $time;
			end
			p = sig(s);
		end
		chk((t1 - t0) / 8, e, nm);
	endtask
	task t_reset;
		rd(5'h01, 8'h00, "main rst");
		rd(5'h02, 8'h00, "filt rst");
		rd(5'h03, 8'h08, "osdiv rst");
		per(2, 2, "sclk div1");
	endtask
	task t_main;
		for (int g = 0; g < 4; g++) begin
			wr(5'h01, 8'h45 | 8'(g << 3));
			chk({out_gain_o, squelch_o}, {g[1:0], g == 3}, "gain");
			chk({power_down_o, aux_select_o, analog_lb_o, digital_lb_o, hw_sec_req_o}, 5'h15, "m1");
		end
		wr(5'h01, 8'h22);
		chk({power_down_o, aux_select_o, analog_lb_o, digital_lb_o, hw_sec_req_o}, 5'h0a, "m0");
		rd(5'h01, 8'h22, "main rb");
		wr(5'h01, 8'h80);
		chk(sr_seen, 1, "soft rst");
		rd(5'h01, 8'h00, "rst bit");
	endtask
	task t_filt;
		@(posedge clock_i) dec_ovf_i <= 1'b1;
		@(posedge clock_i) dec_ovf_i <= 1'b0;
		wr(5'h02, 8'hff);
		chk({flag_o, phone_mode_o, dec_bypass_o, int_bypass_o}, 5'h1f, "filt out");
		rd(5'h02, 8'h3f, "ovf set");
		rd(5'h02, 8'h1f, "ovf clr");
		wr(5'h02, 8'h00);
		chk({flag_o, phone_mode_o, dec_bypass_o, int_bypass_o}, 5'h00, "filt off");
	endtask
	task t_ref;
		wr(5'h05, 8'hff);
		chk(dac_ref_dis_o, 1, "ref dis");
		rd(5'h05, 8'h08, "ref rb");
		wr(5'h05, 8'h00);
		chk(dac_ref_dis_o, 0, "ref en");
	endtask
	task t_nop;
		wr(5'h00, 8'hff);
		rd(5'h00, 8'h00, "nop rd");
		rd(5'h06, 8'h00, "unmapped");
		rd(5'h01, 8'h00, "main kept");
	endtask
	task t_div;
		wr(5'h03, 8'h02);
		per(0, 8, "osclk");
		per(1, 512, "conv");
		wr(5'h03, 8'h00);
		per(0, 1024, "osclk 0");
		wr(5'h04, 8'h03);
		per(2, 6, "sclk");
		wr(5'h04, 8'h00);
		per(2, 512, "sclk 0");
	endtask
	initial begin
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_reset;
		t_main;
		t_filt;
		t_ref;
		t_nop;
		t_div;
		report_and_stop;
	end
endmodule // tb
